// *** logic/rtc_pkg.sv ***
package rtc_pkg;

    // ----------------------------------------------------------------
    // Register indices; the bus byte address is four times the index.
    // ----------------------------------------------------------------
    localparam logic [4:0] RTC_IDX_CTRL = 5'h00;
    localparam logic [4:0] RTC_IDX_STATUS = 5'h01;
    localparam logic [4:0] RTC_IDX_INTEN = 5'h02;
    localparam logic [4:0] RTC_IDX_FLAGS = 5'h03;
    localparam logic [4:0] RTC_IDX_TEMP = 5'h04;
    localparam logic [4:0] RTC_IDX_HALT = 5'h05;
    localparam logic [4:0] RTC_IDX_CRYSTAL_CORRECTION = 5'h06;
    localparam logic [4:0] RTC_IDX_SOURCE_SELECT = 5'h07;
    localparam logic [4:0] RTC_IDX_CNT_LO = 5'h08;
    localparam logic [4:0] RTC_IDX_CNT_HI = 5'h09;
    localparam logic [4:0] RTC_IDX_PER_LO = 5'h0a;
    localparam logic [4:0] RTC_IDX_PER_HI = 5'h0b;
    localparam logic [4:0] RTC_IDX_CMP_LO = 5'h0c;
    localparam logic [4:0] RTC_IDX_CMP_HI = 5'h0d;
    localparam logic [4:0] RTC_IDX_PIT_CTRL = 5'h10;
    localparam logic [4:0] RTC_IDX_PIT_STATUS = 5'h11;
    localparam logic [4:0] RTC_IDX_PIT_INTEN = 5'h12;
    localparam logic [4:0] RTC_IDX_PIT_FLAG = 5'h13;
    localparam logic [4:0] RTC_IDX_PIT_HALT = 5'h15;

    // ----------------------------------------------------------------
    // Field positions, masks and reset values.
    // ----------------------------------------------------------------
    localparam int RTC_SYNC_CTRL = 0;
    localparam int RTC_SYNC_CNT = 1;
    localparam int RTC_SYNC_PER = 2;
    localparam int RTC_SYNC_CMP = 3;
    localparam int RTC_FLAG_WRAP = 0;
    localparam int RTC_FLAG_MATCH = 1;
    localparam logic [7:0] RTC_CTRL_WMASK = 8'hfd;
    localparam logic [7:0] RTC_PIT_CTRL_WMASK = 8'h79;
    localparam logic [7:0] RTC_CTRL_RST = 8'h00;
    localparam logic [15:0] RTC_CNT_RST = 16'h0000;
    localparam logic [15:0] RTC_PER_RST = 16'hffff;
    localparam logic [15:0] RTC_CMP_RST = 16'h0000;

    // ----------------------------------------------------------------
    // Timing.
    // ----------------------------------------------------------------
    localparam int RTC_SYS_CLK_HZ = 10000000;
    localparam int RTC_CLK_HZ = 32768;
    localparam int RTC_TICK_CYCLES = RTC_SYS_CLK_HZ / RTC_CLK_HZ;
    localparam logic [1:0] RTC_SYNC_TICKS = 2'h2;
    localparam logic [19:0] RTC_PPM_INTERVAL = 20'hf4240;

    // ----------------------------------------------------------------
    // Types.
    // ----------------------------------------------------------------
    typedef struct packed {
        logic keep_running_in_sleep;
        logic [3:0] prescale;
        logic freq_fix_enable;
        logic spare;
        logic counter_enable;
    } rtc_ctrl_type;

    typedef struct packed {
        logic sign;
        logic [6:0] error;
    } rtc_crystal_correction_type;

    typedef struct packed {
        logic ack;
        logic [7:0] rdata;
        rtc_ctrl_type ctrl;
        rtc_ctrl_type ctrl_eff;
        logic [1:0] inten;
        logic [1:0] flags;
        logic [7:0] temp;
        logic run_while_halted;
        rtc_crystal_correction_type crystal_correction;
        logic [1:0] source_select;
        logic [15:0] cnt;
        logic [15:0] cnt_wr;
        logic [15:0] per_wr;
        logic [15:0] per_eff;
        logic [15:0] cmp_wr;
        logic [15:0] cmp_eff;
        logic [3:0][1:0] sync_cnt;
        logic [7:0] pit_ctrl;
        logic pit_inten;
        logic pit_flag;
        logic pit_run_while_halted;
        logic [15:0] div_cnt;
        logic [14:0] pre;
        logic [19:0] acc;
        logic wrap_pulse;
        logic match_pulse;
    } rtc_state_type;

endpackage

// *** logic/rtc_register_interface.sv ***
`timescale 1ns/1ps
module rtc_register_interface #(
    parameter int RTC_DIV = rtc_pkg::RTC_TICK_CYCLES
) (
    input wire logic clock, // System clock, 10 MHz.
    input wire logic resetn, // Asynchronous reset, active low.
    input wire logic [6:0] address, // Avalon byte address.
    input wire logic read, // Avalon read request.
    input wire logic write, // Avalon write request.
    input wire logic [3:0] byteenable, // Avalon byte enables.
    input wire logic [31:0] writedata, // Avalon write data.
    output logic [31:0] readdata, // Avalon read data.
    output logic waitrequest, // Avalon wait request.
    input wire logic standby_sleep, // Device is in standby sleep.
    input wire logic cpu_halted, // CPU is halted by the debugger.
    output logic irq, // Counter interrupt request.
    output logic wrap_event, // One-cycle pulse on wrap.
    output logic compare_match // One-cycle pulse on compare match.
);
    import rtc_pkg::*;

    // ----------------------------------------------------------------
    // Helpers.
    // ----------------------------------------------------------------
    function automatic rtc_state_type reset_state();
        rtc_state_type st;
        st = '0;
        st.ctrl = rtc_ctrl_type'(RTC_CTRL_RST);
        st.ctrl_eff = rtc_ctrl_type'(RTC_CTRL_RST);
        st.cnt = RTC_CNT_RST;
        st.cnt_wr = RTC_CNT_RST;
        st.per_wr = RTC_PER_RST;
        st.per_eff = RTC_PER_RST;
        st.cmp_wr = RTC_CMP_RST;
        st.cmp_eff = RTC_CMP_RST;
        return st;
    endfunction

    localparam rtc_state_type RTC_STATE_RST = reset_state();
    localparam logic [15:0] DIV_LAST = 16'(RTC_DIV - 1);

    // The prescaler hits once all bits below the chosen power are ones.
    function automatic logic prescale_hit(input logic [14:0] pre, input logic [3:0] code);
        logic [14:0] mask;
        mask = 15'((16'h0001 << code) - 16'h0001);
        return (pre & mask) == mask;
    endfunction

    function automatic logic [7:0] read_reg(input rtc_state_type st, input logic [4:0] idx);
        logic [7:0] v;
        v = 8'h00;
        case (idx)
            RTC_IDX_CTRL: v = st.ctrl;
            RTC_IDX_STATUS: begin
                for (int i = 0; i < 4; i++) begin
                    v[i] = st.sync_cnt[i] != 2'h0;
                end
            end
            RTC_IDX_INTEN: v = {6'h00, st.inten};
            RTC_IDX_FLAGS: v = {6'h00, st.flags};
            RTC_IDX_TEMP: v = st.temp;
            RTC_IDX_HALT: v = {7'h00, st.run_while_halted};
            RTC_IDX_CRYSTAL_CORRECTION: v = st.crystal_correction;
            RTC_IDX_SOURCE_SELECT: v = {6'h00, st.source_select};
            RTC_IDX_CNT_LO: v = st.cnt[7:0];
            RTC_IDX_CNT_HI: v = st.temp;
            RTC_IDX_PER_LO: v = st.per_wr[7:0];
            RTC_IDX_PER_HI: v = st.temp;
            RTC_IDX_CMP_LO: v = st.cmp_wr[7:0];
            RTC_IDX_CMP_HI: v = st.temp;
            RTC_IDX_PIT_CTRL: v = st.pit_ctrl;
            RTC_IDX_PIT_STATUS: v = 8'h00;
            RTC_IDX_PIT_INTEN: v = {7'h00, st.pit_inten};
            RTC_IDX_PIT_FLAG: v = {7'h00, st.pit_flag};
            RTC_IDX_PIT_HALT: v = {7'h00, st.pit_run_while_halted};
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    // ----------------------------------------------------------------
    // Reset release.
    // ----------------------------------------------------------------
    logic [1:0] rst_sync_q;
    logic rst_n;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_q[1];

    // ----------------------------------------------------------------
    // Next state.
    // ----------------------------------------------------------------
    rtc_state_type state_q;
    rtc_state_type state_d;
    logic rtc_tick;
    logic run;
    logic corr;
    logic hit;
    logic [20:0] acc_sum;
    logic [3:0] apply;
    logic [1:0] flag_set;
    logic [1:0] flag_clr;
    logic [15:0] cnt_next;
    logic [4:0] idx;
    logic req;
    logic commit_wr;
    logic [7:0] wbyte;

    assign idx = address[6:2];
    assign req = read | write;
    assign waitrequest = req & ~state_q.ack;
    assign readdata = {24'h000000, state_q.rdata};
    assign irq = |(state_q.flags & state_q.inten);
    assign wrap_event = state_q.wrap_pulse;
    assign compare_match = state_q.match_pulse;

    always_comb begin
        state_d = state_q;
        state_d.wrap_pulse = 1'b0;
        state_d.match_pulse = 1'b0;
        apply = 4'h0;
        flag_set = 2'h0;
        flag_clr = 2'h0;
        corr = 1'b0;
        hit = 1'b0;
        acc_sum = {1'b0, state_q.acc} + {14'h0000, state_q.crystal_correction.error};
        cnt_next = state_q.cnt;
        wbyte = writedata[7:0];
        commit_wr = write & state_q.ack & byteenable[0];

        // RTC tick divider; every counter-side action except the prescaler and accumulator clear while disabled waits for this pulse.
        rtc_tick = state_q.div_cnt == DIV_LAST;
        state_d.div_cnt = rtc_tick ? 16'h0000 : state_q.div_cnt + 16'h0001;

        // Written values walk two RTC ticks before reaching the counter.
        for (int i = 0; i < 4; i++) begin
            if (rtc_tick && state_q.sync_cnt[i] != 2'h0) begin
                state_d.sync_cnt[i] = state_q.sync_cnt[i] - 2'h1;
                apply[i] = state_q.sync_cnt[i] == 2'h1;
            end
        end
        if (apply[RTC_SYNC_CTRL]) begin
            state_d.ctrl_eff = state_q.ctrl;
        end
        if (apply[RTC_SYNC_PER]) begin
            state_d.per_eff = state_q.per_wr;
        end
        if (apply[RTC_SYNC_CMP]) begin
            state_d.cmp_eff = state_q.cmp_wr;
        end

        run = state_q.ctrl_eff.counter_enable
            & (~standby_sleep | state_q.ctrl_eff.keep_running_in_sleep)
            & (~cpu_halted | state_q.run_while_halted);

        // ------------------------------------------------------------
        // Prescaler with crystal correction.
        // ------------------------------------------------------------
        // Correction is spread by a PPM accumulator: one extra or missing
        // prescaler step each time the error summed over RTC ticks reaches a million.
        if (rtc_tick && run) begin
            if (state_q.ctrl_eff.freq_fix_enable) begin
                corr = acc_sum >= {1'b0, RTC_PPM_INTERVAL};
                state_d.acc = corr ? 20'(acc_sum - {1'b0, RTC_PPM_INTERVAL}) : acc_sum[19:0];
            end
            if (corr && !state_q.crystal_correction.sign) begin
                hit = 1'b0;
            end else if (corr && state_q.crystal_correction.sign) begin
                state_d.pre = state_q.pre + 15'h0002;
                hit = prescale_hit(state_q.pre, state_q.ctrl_eff.prescale)
                    | prescale_hit(state_q.pre + 15'h0001, state_q.ctrl_eff.prescale);
            end else begin
                state_d.pre = state_q.pre + 15'h0001;
                hit = prescale_hit(state_q.pre, state_q.ctrl_eff.prescale);
            end
        end
        if (!state_q.ctrl_eff.counter_enable) begin
            state_d.pre = 15'h0000;
            state_d.acc = 20'h00000;
        end

        // ------------------------------------------------------------
        // Counter, wrap and compare.
        // ------------------------------------------------------------
        if (apply[RTC_SYNC_CNT]) begin
            state_d.cnt = state_q.cnt_wr;
        end else if (hit) begin
            if (state_q.cnt == state_q.per_eff) begin
                cnt_next = 16'h0000;
                flag_set[RTC_FLAG_WRAP] = 1'b1;
            end else begin
                cnt_next = state_q.cnt + 16'h0001;
            end
            flag_set[RTC_FLAG_MATCH] = cnt_next == state_q.cmp_eff;
            state_d.cnt = cnt_next;
        end
        state_d.wrap_pulse = flag_set[RTC_FLAG_WRAP];
        state_d.match_pulse = flag_set[RTC_FLAG_MATCH];

        // ------------------------------------------------------------
        // Avalon slave: one wait cycle, then the access completes.
        // ------------------------------------------------------------
        if (req && !state_q.ack) begin
            state_d.ack = 1'b1;
            state_d.rdata = read ? read_reg(state_q, idx) : 8'h00;
            // High byte is latched with the low byte so the pair is coherent.
            if (read) begin
                case (idx)
                    RTC_IDX_CNT_LO: state_d.temp = state_q.cnt[15:8];
                    RTC_IDX_PER_LO: state_d.temp = state_q.per_wr[15:8];
                    RTC_IDX_CMP_LO: state_d.temp = state_q.cmp_wr[15:8];
                    default: state_d.temp = state_q.temp;
                endcase
            end
        end else begin
            state_d.ack = 1'b0;
        end

        if (commit_wr) begin
            case (idx)
                RTC_IDX_CTRL: begin
                    state_d.ctrl = rtc_ctrl_type'(wbyte & RTC_CTRL_WMASK);
                    state_d.sync_cnt[RTC_SYNC_CTRL] = RTC_SYNC_TICKS;
                end
                RTC_IDX_INTEN: state_d.inten = wbyte[1:0];
                RTC_IDX_FLAGS: flag_clr = wbyte[1:0];
                RTC_IDX_TEMP: state_d.temp = wbyte;
                RTC_IDX_HALT: state_d.run_while_halted = wbyte[0];
                RTC_IDX_CRYSTAL_CORRECTION: state_d.crystal_correction = rtc_crystal_correction_type'(wbyte);
                RTC_IDX_SOURCE_SELECT: state_d.source_select = wbyte[1:0];
                RTC_IDX_CNT_LO, RTC_IDX_PER_LO, RTC_IDX_CMP_LO: begin
                    state_d.temp = wbyte;
                end
                RTC_IDX_CNT_HI: begin
                    state_d.cnt_wr = {wbyte, state_q.temp};
                    state_d.sync_cnt[RTC_SYNC_CNT] = RTC_SYNC_TICKS;
                end
                RTC_IDX_PER_HI: begin
                    state_d.per_wr = {wbyte, state_q.temp};
                    state_d.sync_cnt[RTC_SYNC_PER] = RTC_SYNC_TICKS;
                end
                RTC_IDX_CMP_HI: begin
                    state_d.cmp_wr = {wbyte, state_q.temp};
                    state_d.sync_cnt[RTC_SYNC_CMP] = RTC_SYNC_TICKS;
                end
                RTC_IDX_PIT_CTRL: state_d.pit_ctrl = wbyte & RTC_PIT_CTRL_WMASK;
                RTC_IDX_PIT_INTEN: state_d.pit_inten = wbyte[0];
                RTC_IDX_PIT_FLAG: state_d.pit_flag = state_q.pit_flag & ~wbyte[0];
                RTC_IDX_PIT_HALT: state_d.pit_run_while_halted = wbyte[0];
                default: state_d.temp = state_d.temp;
            endcase
        end

        // A hardware event in the same cycle as a clear keeps the flag set.
        state_d.flags = (state_q.flags & ~flag_clr) | flag_set;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= RTC_STATE_RST;
        end else begin
            state_q <= state_d;
        end
    end

endmodule

// *** verif/rtc_register_interface_sva.sv ***
`timescale 1ns/1ps
module rtc_register_interface_sva #(
    parameter int RTC_DIV = 4
) (
    input wire logic clock, // System clock.
    input wire logic resetn, // Reset, active low.
    input wire logic [6:0] address, // Byte address.
    input wire logic read, // Read request.
    input wire logic write, // Write request.
    input wire logic [3:0] byteenable, // Byte enables.
    input wire logic [31:0] writedata, // Write data.
    input wire logic [31:0] readdata, // Read data.
    input wire logic waitrequest, // Wait request.
    input wire logic standby_sleep, // Standby sleep.
    input wire logic cpu_halted, // Debugger halt.
    input wire logic irq, // Interrupt request.
    input wire logic wrap_event, // Wrap pulse.
    input wire logic compare_match // Match pulse.
);
    // ----------------------------------------------------------------
    // Bus and interrupt relations
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    logic irq_wr;
    assign irq_wr = write && !waitrequest && (address[6:2] == 5'h02 || address[6:2] == 5'h03);
    sequence s_done;
        (read || write) && !waitrequest;
    endsequence
    sequence s_pending;
        (read || write) && waitrequest;
    endsequence
    chk_wait_first: assert property ($rose(read || write) |-> waitrequest)
        else $error("wait missing on new request");
    chk_one_wait: assert property (s_pending |=> !waitrequest)
        else $error("answer late");
    chk_new_wait: assert property (s_done |=> !(read || write) || waitrequest)
        else $error("no wait on back to back request");
    chk_read_hold: assert property (read && !waitrequest |=> $stable(readdata))
        else $error("read data moved");
    chk_upper_zero: assert property (readdata[31:8] == 24'h000000)
        else $error("upper read bits set");
    chk_unmapped_zero: assert property (read && !waitrequest &&
        (address[6:2] inside {5'h0e, 5'h0f, 5'h14, [5'h16:5'h1f]}) |-> readdata == 32'h0)
        else $error("unmapped read not zero");
    chk_wrap_single: assert property (wrap_event |=> !wrap_event [*3])
        else $error("wrap pulse too long");
    chk_match_single: assert property (compare_match |=> !compare_match [*3])
        else $error("match pulse too long");
    chk_irq_fall: assert property ($fell(irq) |-> $past(irq_wr))
        else $error("irq dropped without a write");
    chk_irq_rise: assert property ($rose(irq) |->
        wrap_event || compare_match || $past(irq_wr))
        else $error("irq rose without cause");
endmodule

// *** verif/tb_rtc_register_interface.sv ***
`timescale 1ns/1ps
module tb_rtc_register_interface;
    import rtc_pkg::*;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic [6:0] address = 7'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [3:0] byteenable = 4'hf;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic waitrequest;
    logic standby_sleep = 1'b0;
    logic cpu_halted = 1'b0;
    logic irq, wrap_event, compare_match;
    int err_count = 0;
    int checked = 0;
    int cycles = 0;
    logic [7:0] q;
    int n, kw, km;

    always #50 clock = ~clock;

    rtc_register_interface #(.RTC_DIV(4)) uut (.clock(clock), .resetn(resetn),
        .address(address), .read(read), .write(write), .byteenable(byteenable),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .standby_sleep(standby_sleep), .cpu_halted(cpu_halted), .irq(irq),
        .wrap_event(wrap_event), .compare_match(compare_match));

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic finish_test();
        $display("Mismatches %0d, comparisons %0d", err_count, checked);
        if (err_count == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            err_count++;
            finish_test();
        end
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // The request stands until waitrequest is seen low at a rising edge.
    // Read data are taken at that same edge, and only then is it released.
    task automatic bus(input logic we, input logic [4:0] idx, input logic [7:0] d,
                       output logic [7:0] rq);
        @(posedge clock);
        read <= !we;
        write <= we;
        address <= {idx, 2'b00};
        writedata <= {24'h0, d};
        do begin
            @(posedge clock);
        end while (waitrequest !== 1'b0);
        rq = readdata[7:0];
        read <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic wr(input logic [4:0] idx, input logic [7:0] d);
        logic [7:0] dummy;
        bus(1'b1, idx, d, dummy);
    endtask

    task automatic rd(input logic [4:0] idx, output logic [7:0] rq);
        bus(1'b0, idx, 8'h00, rq);
    endtask

    task automatic wr16(input logic [4:0] idx, input logic [15:0] v, input logic [7:0] busy);
        wr(idx, v[7:0]);
        wr(5'(idx + 5'h01), v[15:8]);
        rd(RTC_IDX_STATUS, q);
        chk(q, busy);
    endtask

    task automatic wait_sync();
        int k;
        k = 0;
        do begin
            rd(RTC_IDX_STATUS, q);
            k++;
        end while (q !== 8'h00 && k < 20);
        chk(q, 8'h00);
    endtask

    task automatic gap(output int g);
        g = 0;
        do begin
            @(negedge clock);
            g++;
        end while (wrap_event !== 1'b1 && g < 3000);
    endtask

    task automatic pulses(input int exp);
        kw = 0;
        km = 0;
        // A pulse launched by the edge that changed an input is skipped.
        @(posedge clock);
        repeat (40) begin
            @(negedge clock);
            if (wrap_event === 1'b1) kw++;
            if (compare_match === 1'b1) km++;
        end
        chk(8'(kw), 8'(exp));
        chk(8'(km), 8'(exp));
    endtask

    task automatic chk_irq(input logic [7:0] exp);
        @(negedge clock);
        chk({7'h00, irq}, exp);
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset_values();
        for (int i = 0; i < 5; i++) begin
            rd(5'(i), q);
            chk(q, 8'h00);
        end
        rd(RTC_IDX_PER_LO, q);
        chk(q, 8'hff);
        rd(RTC_IDX_PER_HI, q);
        chk(q, 8'hff);
        wr(RTC_IDX_STATUS, 8'hff);
        rd(RTC_IDX_STATUS, q);
        chk(q, 8'h00);
        wr(5'h0e, 8'h55);
        rd(5'h0e, q);
        chk(q, 8'h00);
    endtask

    task automatic t_holding();
        wr16(RTC_IDX_CNT_LO, 16'h1234, 8'h02);
        wait_sync();
        rd(RTC_IDX_CNT_LO, q);
        chk(q, 8'h34);
        rd(RTC_IDX_TEMP, q);
        chk(q, 8'h12);
        wr(RTC_IDX_TEMP, 8'h5a);
        rd(RTC_IDX_CNT_HI, q);
        chk(q, 8'h5a);
        wr16(RTC_IDX_CNT_LO, 16'h0000, 8'h02);
        wait_sync();
        wr16(RTC_IDX_PER_LO, 16'h0000, 8'h04);
        wait_sync();
        wr16(RTC_IDX_CMP_LO, 16'h0000, 8'h08);
        wait_sync();
    endtask

    task automatic t_prescale();
        for (int p = 0; p < 4; p++) begin
            wr(RTC_IDX_CTRL, {1'b0, 4'(p), 3'b101});
            rd(RTC_IDX_STATUS, q);
            chk(q, 8'h01);
            wait_sync();
            rd(RTC_IDX_CTRL, q);
            chk(q, {1'b0, 4'(p), 3'b101});
            gap(n);
            gap(n);
            chk(8'(n), 8'(4 << p));
        end
    endtask

    task automatic t_sleep();
        wr(RTC_IDX_CTRL, 8'h01);
        wait_sync();
        pulses(10);
        @(posedge clock) standby_sleep <= 1'b1;
        pulses(0);
        wr(RTC_IDX_CTRL, 8'h81);
        wait_sync();
        pulses(10);
        @(posedge clock) standby_sleep <= 1'b0;
        cpu_halted <= 1'b1;
        pulses(0);
        @(posedge clock) cpu_halted <= 1'b0;
        wr(RTC_IDX_CTRL, 8'h00);
        wait_sync();
        pulses(0);
    endtask

    task automatic t_flags();
        rd(RTC_IDX_FLAGS, q);
        chk(q, 8'h03);
        chk_irq(8'h00);
        wr(RTC_IDX_INTEN, 8'h02);
        chk_irq(8'h01);
        wr(RTC_IDX_FLAGS, 8'h02);
        chk_irq(8'h00);
        rd(RTC_IDX_FLAGS, q);
        chk(q, 8'h01);
        wr(RTC_IDX_INTEN, 8'h01);
        chk_irq(8'h01);
        wr(RTC_IDX_FLAGS, 8'h00);
        chk_irq(8'h01);
        @(posedge clock) byteenable <= 4'he;
        wr(RTC_IDX_FLAGS, 8'h01);
        chk_irq(8'h01);
        @(posedge clock) byteenable <= 4'hf;
        wr(RTC_IDX_FLAGS, 8'h01);
        chk_irq(8'h00);
    endtask

    initial begin
        repeat (6) @(posedge clock);
        resetn <= 1'b1;
        repeat (3) @(posedge clock);
        t_reset_values();
        t_holding();
        t_prescale();
        t_sleep();
        t_flags();
        finish_test();
    end
endmodule

bind rtc_register_interface rtc_register_interface_sva #(.RTC_DIV(RTC_DIV)) chk_i (
    .clock(clock), .resetn(resetn), .address(address), .read(read), .write(write),
    .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .standby_sleep(standby_sleep), .cpu_halted(cpu_halted),
    .irq(irq), .wrap_event(wrap_event), .compare_match(compare_match));
